// >>> inc/dmu_pkg.sv
// Constants, decode tables and carrier types of the sectored data memory unit
// Overview of operation
// - Control registers low half sectors 0-1, RAM high half
// - Program bank select never steers data decoding
// - Sector-capable ports: sector from high, offset from low
// - Twelve-bit address: high four bits sector, low byte offset
// - Direct access reaches every sector
// - Unused control locations read zero
// - Read-only control registers ignore core writes
// - Byte RAM fully writable, per-bit set or clear
// - Port addresses redirect to pointed location, hold nothing
// - First port sector 0 only; others any sector
// - Indirect access to a port: zero, no write
// - Five pointers are ordinary read/write storage
// - Every location is eight bits wide
package dmu_pkg;

  // ----------------------------------------
  // Geometry
  // ----------------------------------------
  localparam int DMU_AW = 12;
  localparam int DMU_DW = 8;
  localparam int DMU_SEC_W = 4;
  localparam int DMU_GPR_DEPTH = 2048;
  localparam int DMU_SFR_DEPTH = 256;
  localparam int DMU_GPR_IW = 11;
  localparam int DMU_SFR_IW = 8;
  localparam int DMU_BANK_W = 2;

  localparam logic [DMU_SEC_W-1:0] DMU_SEC_ZERO = 4'h0;
  localparam logic [DMU_SEC_W-1:0] DMU_SEC_SFR_LAST = 4'h1;
  localparam logic [DMU_DW-1:0] DMU_SFR_RST = 8'h00;
  localparam logic [DMU_DW-1:0] DMU_ZERO = 8'h00;
  localparam logic [DMU_DW-1:0] DMU_FULL_MASK = 8'hff;

  // ----------------------------------------
  // Offsets in sector 0
  // ----------------------------------------
  localparam logic [7:0] DMU_OFS_PORT0 = 8'h00;
  localparam logic [7:0] DMU_OFS_PTR0 = 8'h01;
  localparam logic [7:0] DMU_OFS_PORTA = 8'h02;
  localparam logic [7:0] DMU_OFS_PTRA_LO = 8'h03;
  localparam logic [7:0] DMU_OFS_PTRA_SEC = 8'h04;
  localparam logic [7:0] DMU_OFS_BANK_SEL = 8'h0b;
  localparam logic [7:0] DMU_OFS_PORTB = 8'h0c;
  localparam logic [7:0] DMU_OFS_PTRB_LO = 8'h0d;
  localparam logic [7:0] DMU_OFS_PTRB_SEC = 8'h0e;
  localparam logic [7:0] DMU_OFS_TBL_HIGH = 8'h08;

  // ----------------------------------------
  // Decode functions; unused and read-only take control index {sector bit, offset[6:0]}, port test takes sector and offset
  // ----------------------------------------
  function automatic logic dmu_sfr_unused(input logic [DMU_SFR_IW-1:0] idx);
    case (idx) inside
      8'h2a, 8'h2b, [8'h45:8'h48], [8'h59:8'h5f], 8'h62, 8'h63: dmu_sfr_unused = 1'b1;
      [8'h80:8'haf], 8'hc1, 8'hc2, [8'hd0:8'hd2], [8'he5:8'hff]: dmu_sfr_unused = 1'b1;
      default: dmu_sfr_unused = 1'b0;
    endcase
  endfunction

  // Table high byte is loaded by hardware only
  function automatic logic dmu_sfr_ro(input logic [DMU_SFR_IW-1:0] idx);
    dmu_sfr_ro = (idx == DMU_OFS_TBL_HIGH);
  endfunction

  function automatic logic dmu_is_port(input logic [DMU_SEC_W-1:0] sec, input logic [7:0] ofs);
    dmu_is_port = (sec == DMU_SEC_ZERO) &&
                  ((ofs == DMU_OFS_PORT0) || (ofs == DMU_OFS_PORTA) || (ofs == DMU_OFS_PORTB));
  endfunction

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic rd;
    logic wr;
    logic [DMU_AW-1:0] addr;
    logic [DMU_DW-1:0] wdata;
    logic [DMU_DW-1:0] wmask;
  } dmu_req_t;

  typedef struct packed {
    logic valid;
    logic [DMU_SFR_IW-1:0] idx;
    logic [DMU_DW-1:0] data;
  } dmu_hw_upd_t;

  typedef struct packed {
    logic valid;
    logic [DMU_DW-1:0] data;
  } dmu_rsp_t;

endpackage

// >>> design/dmu_addr_unit.sv
// Sectored data memory address decode, indirect ports and storage
module dmu_addr_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Core access
  input wire dmu_pkg::dmu_req_t req_i,
  output dmu_pkg::dmu_rsp_t rsp_o,
  // Hardware update of control registers
  input wire dmu_pkg::dmu_hw_upd_t hw_upd_i,
  // Program memory bank select
  output logic [dmu_pkg::DMU_BANK_W-1:0] program_bank_select_o
);
  import dmu_pkg::*;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  // Byte-wide locations
  logic [DMU_DW-1:0] sfr_r [DMU_SFR_DEPTH];
  logic [DMU_DW-1:0] gpr_r [DMU_GPR_DEPTH];

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic [DMU_SEC_W-1:0] dir_sec;
  logic [7:0] dir_ofs;
  logic port0_hit;
  logic porta_hit;
  logic portb_hit;
  logic ind_hit;
  logic [DMU_SEC_W-1:0] eff_sec;
  logic [7:0] eff_ofs;
  logic tgt_void;
  logic eff_gpr;
  logic eff_sfr;
  logic eff_ro;
  logic [DMU_GPR_IW-1:0] gidx;
  logic [DMU_SFR_IW-1:0] sidx;
  logic [DMU_DW-1:0] rd_val;
  logic [DMU_DW-1:0] old_val;
  logic [DMU_DW-1:0] wr_val;

  assign dir_sec = req_i.addr[DMU_AW-1:8];
  assign dir_ofs = req_i.addr[7:0];

  assign port0_hit = (dir_sec == DMU_SEC_ZERO) && (dir_ofs == DMU_OFS_PORT0);
  assign porta_hit = (dir_sec == DMU_SEC_ZERO) && (dir_ofs == DMU_OFS_PORTA);
  assign portb_hit = (dir_sec == DMU_SEC_ZERO) && (dir_ofs == DMU_OFS_PORTB);
  assign ind_hit = port0_hit || porta_hit || portb_hit;

  // Bank select deliberately absent from this decode
  // No data sector pointer
  always_comb begin
    eff_sec = dir_sec;
    eff_ofs = dir_ofs;
    // First port fixed to sector 0
    if (port0_hit) begin
      eff_sec = DMU_SEC_ZERO;
      eff_ofs = sfr_r[DMU_OFS_PTR0];
    end else if (porta_hit) begin
      eff_sec = sfr_r[DMU_OFS_PTRA_SEC][DMU_SEC_W-1:0];
      eff_ofs = sfr_r[DMU_OFS_PTRA_LO];
    end else if (portb_hit) begin
      eff_sec = sfr_r[DMU_OFS_PTRB_SEC][DMU_SEC_W-1:0];
      eff_ofs = sfr_r[DMU_OFS_PTRB_LO];
    end
  end

  // Port aimed at port is void
  assign tgt_void = ind_hit && dmu_is_port(eff_sec, eff_ofs);

  // Low half control, high half RAM
  assign gidx = {eff_sec, eff_ofs[6:0]};
  assign sidx = {eff_sec[0], eff_ofs[6:0]};
  assign eff_gpr = eff_ofs[7];
  assign eff_sfr = !eff_ofs[7] && (eff_sec <= DMU_SEC_SFR_LAST) && !dmu_sfr_unused(sidx) &&
                   !dmu_is_port(eff_sec, eff_ofs);
  assign eff_ro = dmu_sfr_ro(sidx);

  // Read mux, zero for anything that holds no storage
  always_comb begin
    old_val = DMU_ZERO;
    if (eff_gpr) begin
      old_val = gpr_r[gidx];
    end else if (eff_sfr) begin
      old_val = sfr_r[sidx];
    end
  end
  assign rd_val = tgt_void ? DMU_ZERO : old_val;

  assign wr_val = (old_val & ~req_i.wmask) | (req_i.wdata & req_i.wmask);

  // ----------------------------------------
  // General RAM
  // ----------------------------------------
  // Data storage, no reset to save area
  // Core writes RAM
  always_ff @(posedge clk_i) begin
    if (req_i.wr && eff_gpr) begin
      gpr_r[gidx] <= wr_val;
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Hardware update wins over a core write in the same cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < DMU_SFR_DEPTH; i++) begin
        sfr_r[i] <= DMU_SFR_RST;
      end
    end else begin
      if (req_i.wr && eff_sfr && !eff_ro) begin
        sfr_r[sidx] <= wr_val;
      end
      if (hw_upd_i.valid) begin
        sfr_r[hw_upd_i.idx] <= hw_upd_i.data;
      end
    end
  end

  assign program_bank_select_o = sfr_r[DMU_OFS_BANK_SEL][DMU_BANK_W-1:0];

  // ----------------------------------------
  // Read response
  // ----------------------------------------
  // One cycle for direct and indirect alike
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.rd;
      if (req_i.rd) begin
        rsp_o.data <= rd_val;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  a_rd_latency: assert property (req_i.rd |=> rsp_o.valid)
    else $error("read answer not one cycle after request");
  a_no_stray_valid: assert property (!req_i.rd |=> !rsp_o.valid)
    else $error("answer without read");
  a_unused_zero: assert property (req_i.rd && !ind_hit && !dir_ofs[7] &&
                                  ((dir_sec > DMU_SEC_SFR_LAST) || dmu_sfr_unused(sidx)) |=> rsp_o.data == DMU_ZERO)
    else $error("unused location did not read zero");
  a_port_self_zero: assert property (req_i.rd && tgt_void |=> rsp_o.data == DMU_ZERO)
    else $error("indirect read of port not zero");
  a_port_no_store: assert property (req_i.wr && port0_hit && !hw_upd_i.valid |=>
                                    $stable(sfr_r[DMU_OFS_PORT0]))
    else $error("port address took a write");
  a_ro_hold: assert property (req_i.wr && eff_sfr && eff_ro && !hw_upd_i.valid |=>
                              sfr_r[$past(sidx)] == $past(old_val))
    else $error("read-only register changed");
  a_gpr_write: assert property (req_i.wr && eff_gpr && req_i.wmask == DMU_FULL_MASK |=>
                                gpr_r[$past(gidx)] == $past(req_i.wdata))
    else $error("RAM byte write lost");
  a_bit_clear: assert property (req_i.wr && eff_gpr && req_i.wdata == DMU_ZERO |=>
                                (gpr_r[$past(gidx)] & $past(req_i.wmask)) == DMU_ZERO)
    else $error("RAM bit clear failed");
  a_port0_sector0: assert property (port0_hit |-> eff_sec == DMU_SEC_ZERO &&
                                    eff_ofs == sfr_r[DMU_OFS_PTR0])
    else $error("first port left sector 0");
  a_ptr_redirect: assert property (portb_hit |-> eff_sec == sfr_r[DMU_OFS_PTRB_SEC][DMU_SEC_W-1:0] &&
                                   gidx[6:0] == sfr_r[DMU_OFS_PTRB_LO][6:0])
    else $error("second pointer pair not used");
  a_ptr_rw: assert property (req_i.wr && !ind_hit && dir_sec == DMU_SEC_ZERO &&
                             dir_ofs == DMU_OFS_PTRA_SEC && req_i.wmask == DMU_FULL_MASK && !hw_upd_i.valid
                             |=> sfr_r[DMU_OFS_PTRA_SEC] == $past(req_i.wdata))
    else $error("pointer write lost");

  // ----------------------------------------
  // Data path assertions
  // ----------------------------------------
  // Data held between reads
  a_rd_data_held: assert property (
    !req_i.rd
    |=> $stable(rsp_o.data))
    else $error("read data changed without read");

  a_rd_back_to_back: assert property (
    req_i.rd ##1 req_i.rd
    |=> rsp_o.valid)
    else $error("second read in a row unanswered");

  a_direct_ram_rd: assert property (
    req_i.rd && !ind_hit && dir_ofs[7]
    |=> rsp_o.data == $past(gpr_r[{dir_sec, dir_ofs[6:0]}]))
    else $error("direct RAM read wrong");

  a_ptr0_rd: assert property (
    req_i.rd && dir_sec == DMU_SEC_ZERO && dir_ofs == DMU_OFS_PTR0
    |=> rsp_o.data == $past(sfr_r[DMU_OFS_PTR0]))
    else $error("pointer read wrong");

  a_port0_ram_rd: assert property (
    req_i.rd && port0_hit && sfr_r[DMU_OFS_PTR0][7]
    |=> rsp_o.data == $past(gpr_r[{DMU_SEC_ZERO, sfr_r[DMU_OFS_PTR0][6:0]}]))
    else $error("first port RAM read wrong");

  a_port0_ctrl_rd: assert property (
    req_i.rd && port0_hit && !sfr_r[DMU_OFS_PTR0][7] && !dmu_is_port(DMU_SEC_ZERO, sfr_r[DMU_OFS_PTR0]) &&
    !dmu_sfr_unused({1'b0, sfr_r[DMU_OFS_PTR0][6:0]})
    |=> rsp_o.data == $past(sfr_r[{1'b0, sfr_r[DMU_OFS_PTR0][6:0]}]))
    else $error("first port control read wrong");

  a_porta_ram_rd: assert property (
    req_i.rd && porta_hit && sfr_r[DMU_OFS_PTRA_LO][7]
    |=> rsp_o.data == $past(gpr_r[{sfr_r[DMU_OFS_PTRA_SEC][DMU_SEC_W-1:0], sfr_r[DMU_OFS_PTRA_LO][6:0]}]))
    else $error("port a RAM read wrong");

  a_portb_ram_rd: assert property (
    req_i.rd && portb_hit && sfr_r[DMU_OFS_PTRB_LO][7]
    |=> rsp_o.data == $past(gpr_r[{sfr_r[DMU_OFS_PTRB_SEC][DMU_SEC_W-1:0], sfr_r[DMU_OFS_PTRB_LO][6:0]}]))
    else $error("port b RAM read wrong");

  a_porta_ram_wr: assert property (
    req_i.wr && porta_hit && sfr_r[DMU_OFS_PTRA_LO][7] && req_i.wmask == DMU_FULL_MASK
    |=> gpr_r[$past({sfr_r[DMU_OFS_PTRA_SEC][DMU_SEC_W-1:0], sfr_r[DMU_OFS_PTRA_LO][6:0]})] ==
        $past(req_i.wdata))
    else $error("port a write not at pointer");

  a_porta_pair: assert property (
    porta_hit
    |-> eff_sec == sfr_r[DMU_OFS_PTRA_SEC][DMU_SEC_W-1:0] && eff_ofs == sfr_r[DMU_OFS_PTRA_LO])
    else $error("port a pair not used");

  a_portb_ofs: assert property (
    portb_hit
    |-> eff_ofs == sfr_r[DMU_OFS_PTRB_LO])
    else $error("port b offset not used");

  a_direct_pass: assert property (
    !ind_hit
    |-> eff_sec == req_i.addr[DMU_AW-1:8] && eff_ofs == req_i.addr[7:0])
    else $error("direct address altered");

  a_high_half_ram: assert property (
    eff_ofs[7]
    |-> eff_gpr && !eff_sfr)
    else $error("high half not RAM");

  a_low_half_ctrl: assert property (
    !eff_ofs[7]
    |-> !eff_gpr)
    else $error("low half decoded as RAM");

  a_far_low_empty: assert property (
    eff_sec > DMU_SEC_SFR_LAST && !eff_ofs[7]
    |-> !eff_sfr)
    else $error("control storage beyond sector 1");

  a_port_not_stored: assert property (
    dmu_is_port(eff_sec, eff_ofs)
    |-> !eff_sfr && !eff_gpr)
    else $error("port location decoded as storage");

  a_void_no_target: assert property (
    req_i.wr && tgt_void
    |-> !eff_sfr && !eff_gpr)
    else $error("indirect write to port reached storage");

  // Port a aimed at port b
  a_porta_void: assert property (
    req_i.rd && porta_hit && sfr_r[DMU_OFS_PTRA_SEC][DMU_SEC_W-1:0] == DMU_SEC_ZERO &&
    sfr_r[DMU_OFS_PTRA_LO] == DMU_OFS_PORTB
    |=> rsp_o.data == DMU_ZERO)
    else $error("port a read of port not zero");

  a_unused_not_stored: assert property (
    !eff_ofs[7] && dmu_sfr_unused(sidx)
    |-> !eff_sfr)
    else $error("unused slot decoded as storage");

  a_bank_write: assert property (
    req_i.wr && !ind_hit && dir_sec == DMU_SEC_ZERO && dir_ofs == DMU_OFS_BANK_SEL &&
    req_i.wmask == DMU_FULL_MASK && !hw_upd_i.valid
    |=> program_bank_select_o == $past(req_i.wdata[DMU_BANK_W-1:0]))
    else $error("bank select write lost");

  a_hw_upd_lands: assert property (
    hw_upd_i.valid
    |=> sfr_r[$past(hw_upd_i.idx)] == $past(hw_upd_i.data))
    else $error("hardware load lost");

  a_ro_direct_hold: assert property (
    req_i.wr && !ind_hit && dir_sec == DMU_SEC_ZERO && dir_ofs == DMU_OFS_TBL_HIGH && !hw_upd_i.valid
    |=> $stable(sfr_r[DMU_OFS_TBL_HIGH]))
    else $error("read-only register took a write");

  a_bit_set: assert property (
    req_i.wr && eff_gpr && req_i.wdata == DMU_FULL_MASK
    |=> (gpr_r[$past(gidx)] & $past(req_i.wmask)) == $past(req_i.wmask))
    else $error("RAM bit set failed");

  a_bit_keep: assert property (
    req_i.wr && eff_gpr
    |=> (gpr_r[$past(gidx)] & ~$past(req_i.wmask)) == ($past(old_val) & ~$past(req_i.wmask)))
    else $error("RAM bits outside mask changed");

  a_sfr_write: assert property (
    req_i.wr && eff_sfr && !eff_ro && req_i.wmask == DMU_FULL_MASK && !(hw_upd_i.valid && hw_upd_i.idx == sidx)
    |=> sfr_r[$past(sidx)] == $past(req_i.wdata))
    else $error("control register write lost");

  a_sfr_rd: assert property (
    req_i.rd && eff_sfr
    |=> rsp_o.data == $past(sfr_r[sidx]))
    else $error("control register read wrong");

  a_gpr_rd: assert property (
    req_i.rd && eff_gpr
    |=> rsp_o.data == $past(gpr_r[gidx]))
    else $error("RAM read wrong");

  c_ind_far_sector: cover property (req_i.rd && porta_hit && eff_gpr && eff_sec > DMU_SEC_SFR_LAST);
  c_void_access: cover property (req_i.wr && tgt_void);
  c_ro_write: cover property (req_i.wr && eff_sfr && eff_ro);
  c_bit_op: cover property (req_i.wr && eff_gpr && req_i.wmask != DMU_FULL_MASK);
  c_port0_ram: cover property (req_i.rd && port0_hit && eff_gpr);

endmodule // dmu_addr_unit

// >>> dv/dmu_core_model.sv
// Core-side model issuing one-cycle data memory requests
module dmu_core_model (
  // Clock
  input wire logic clk_i,
  // Request out, response back
  output dmu_pkg::dmu_req_t req_o,
  input wire dmu_pkg::dmu_rsp_t rsp_i
);
  timeunit 1ns;
  timeprecision 1ps;
  import dmu_pkg::*;

  // ----------------------------------------
  // Request tasks
  // ----------------------------------------
  initial req_o = '0;

  // Released lines show the inverse so a stale address is never reused
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [7:0] m);
    @(negedge clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d, wmask: m};
    @(posedge clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d, wmask: ~m};
  endtask

  task automatic rd(input logic [11:0] a, output logic v, output logic [7:0] d);
    @(negedge clk_i);
    req_o <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: ~req_o.wdata, wmask: 8'h00};
    @(posedge clk_i);
    req_o <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: req_o.wdata, wmask: 8'hff};
    #1;
    v = rsp_i.valid;
    d = rsp_i.data;
  endtask
endmodule // dmu_core_model

// >>> dv/sectored_data_memory_addressing_tb_top.sv
// Self-checking bench of the sectored data memory unit
module sectored_data_memory_addressing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dmu_pkg::*;

  // ----------------------------------------
  // Signals and table
  // ----------------------------------------
  typedef struct {logic wr; logic [11:0] a; logic [7:0] d; logic [7:0] m; logic [7:0] e;} dmu_row_t;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  dmu_req_t req;
  dmu_rsp_t rsp;
  dmu_hw_upd_t hw_upd = '0;
  logic [1:0] bank;
  int n_errors = 0;
  int n_tests = 0;
  logic v;
  logic [7:0] d;
  dmu_row_t rows [$] = '{
    '{1'b1, 12'h080, 8'ha5, 8'hff, 8'h00}, '{1'b0, 12'h080, 8'h00, 8'h00, 8'ha5},
    '{1'b1, 12'hf80, 8'h3c, 8'hff, 8'h00}, '{1'b0, 12'hf80, 8'h00, 8'h00, 8'h3c},
    '{1'b1, 12'h090, 8'h88, 8'hff, 8'h00}, '{1'b1, 12'h190, 8'h77, 8'hff, 8'h00},
    '{1'b0, 12'h090, 8'h00, 8'h00, 8'h88},
    '{1'b1, 12'h001, 8'h80, 8'hff, 8'h00}, '{1'b0, 12'h000, 8'h00, 8'h00, 8'ha5},
    '{1'b0, 12'h001, 8'h00, 8'h00, 8'h80},
    '{1'b1, 12'h004, 8'h01, 8'hff, 8'h00}, '{1'b1, 12'h003, 8'h90, 8'hff, 8'h00},
    '{1'b0, 12'h002, 8'h00, 8'h00, 8'h77},
    '{1'b1, 12'h00e, 8'h0f, 8'hff, 8'h00}, '{1'b1, 12'h00d, 8'h80, 8'hff, 8'h00},
    '{1'b1, 12'h00c, 8'h5a, 8'hff, 8'h00}, '{1'b0, 12'hf80, 8'h00, 8'h00, 8'h5a},
    '{1'b1, 12'h02a, 8'h11, 8'hff, 8'h00}, '{1'b0, 12'h02a, 8'h00, 8'h00, 8'h00},
    '{1'b1, 12'h141, 8'h22, 8'hff, 8'h00}, '{1'b0, 12'h141, 8'h00, 8'h00, 8'h00},
    '{1'b1, 12'h245, 8'h33, 8'hff, 8'h00}, '{1'b0, 12'h245, 8'h00, 8'h00, 8'h00},
    '{1'b1, 12'h080, 8'h02, 8'h02, 8'h00}, '{1'b1, 12'h080, 8'h00, 8'h01, 8'h00},
    '{1'b0, 12'h080, 8'h00, 8'h00, 8'ha6},
    '{1'b1, 12'h001, 8'h02, 8'hff, 8'h00}, '{1'b0, 12'h000, 8'h00, 8'h00, 8'h00},
    '{1'b1, 12'h000, 8'hee, 8'hff, 8'h00}, '{1'b0, 12'h190, 8'h00, 8'h00, 8'h77},
    '{1'b1, 12'h00b, 8'h03, 8'hff, 8'h00}, '{1'b0, 12'h00b, 8'h00, 8'h00, 8'h03},
    '{1'b0, 12'h190, 8'h00, 8'h00, 8'h77}};

  always #12.5 clk_i = ~clk_i;

  dmu_addr_unit dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .req_i(req), .rsp_o(rsp), .hw_upd_i(hw_upd),
    .program_bank_select_o(bank));
  dmu_core_model core (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));

  // ----------------------------------------
  // Checking tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Answer must be valid 1ns after the same edge that takes the read
  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    core.rd(a, v, d);
    chk({7'h00, v}, 8'h01);
    chk(d, exp);
  endtask

  task automatic print_verdict();
    $display("TB: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (10) @(negedge clk_i);
    rst_b_i = 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) core.wr(rows[i].a, rows[i].d, rows[i].m);
      else rdc(rows[i].a, rows[i].e);
    end
    $display("TB: table done");
    chk({6'h00, bank}, 8'h03);
    @(negedge clk_i);
    hw_upd = '{valid: 1'b1, idx: 8'h08, data: 8'h9c};
    @(negedge clk_i);
    hw_upd = '0;
    core.wr(12'h008, 8'h33, 8'hff);
    rdc(12'h008, 8'h9c);
    $display("TB: read-only done");
    @(negedge clk_i);
    rst_b_i = 1'b0;
    @(negedge clk_i);
    chk({6'h00, bank}, 8'h00);
    chk(rsp.data, 8'h00);
    rst_b_i = 1'b1;
    rdc(12'h001, 8'h00);
    rdc(12'h190, 8'h77);
    $display("TB: reset done");
    print_verdict();
  end

  // Run needs well under 200 cycles
  initial begin
    #50us;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule // sectored_data_memory_addressing_tb_top
